// ===== design/awsp_pkg.sv
// Purpose: shared constants and types for the sector write command interpreter
// Assumes: one clock domain, 8-bit task file with 16-bit data register
// Notes:   offsets are register indices on the plain register port
package awsp_pkg;
   // task file offsets
   localparam logic [3:0] AWSP_OFF_DATA    = 4'h0; // sector data, write only
   localparam logic [3:0] AWSP_OFF_FEATURE = 4'h1; // feature on write, error on read
   localparam logic [3:0] AWSP_OFF_SECCNT  = 4'h2; // sector count
   localparam logic [3:0] AWSP_OFF_SECNUM  = 4'h3; // sector number, lba 7-0
   localparam logic [3:0] AWSP_OFF_CYLLO   = 4'h4; // cylinder low, lba 15-8
   localparam logic [3:0] AWSP_OFF_CYLHI   = 4'h5; // cylinder high, lba 23-16
   localparam logic [3:0] AWSP_OFF_DRVHD   = 4'h6; // drive/head, lba 27-24
   localparam logic [3:0] AWSP_OFF_CMD     = 4'h7; // opcode on write, status on read
   // system side registers
   localparam logic [3:0] AWSP_OFF_IRQSTAT = 4'h8; // sticky events, read only
   localparam logic [3:0] AWSP_OFF_IRQCLR  = 4'h9; // write one to clear
   localparam logic [3:0] AWSP_OFF_IRQEN   = 4'hA; // event enables
   localparam logic [3:0] AWSP_OFF_CONFIG  = 4'hB; // security support, frozen flag
   // opcodes
   localparam logic [7:0] AWSP_OP_WRITE_A  = 8'h30;
   localparam logic [7:0] AWSP_OP_WRITE_B  = 8'h31;
   localparam logic [7:0] AWSP_OP_WVERIFY  = 8'h3C;
   localparam logic [7:0] AWSP_OP_WEAR     = 8'hF5;
   // status bit positions
   localparam int AWSP_ST_BSY  = 7;
   localparam int AWSP_ST_DRDY = 6;
   localparam int AWSP_ST_DRQ  = 3;
   localparam int AWSP_ST_ERR  = 0;
   // error bit positions
   localparam int AWSP_ER_MEDIA = 6;
   localparam int AWSP_ER_ABRT  = 2;
   // event bit positions
   localparam int AWSP_EV_DRQ  = 0;
   localparam int AWSP_EV_DONE = 1;
   localparam int AWSP_EV_ERR  = 2;
   localparam int AWSP_EV_N    = 3;
   // config bit positions
   localparam int AWSP_CF_SECURE = 0;
   localparam int AWSP_CF_FROZEN = 1;
   // misc values
   localparam int          AWSP_LBA_MODE_BIT = 6;
   localparam int          AWSP_WORDS_DEF    = 256;
   localparam logic [7:0]  AWSP_SECCNT_ONE   = 8'h01;
   localparam logic [7:0]  AWSP_SECCNT_NONE  = 8'h00;
   localparam logic [27:0] AWSP_LBA_STEP     = 28'h000_0001;
   // command sequencer states
   typedef enum logic [2:0] {
      AWSP_S_IDLE   = 3'b000,
      AWSP_S_START  = 3'b001,
      AWSP_S_DRQ    = 3'b010,
      AWSP_S_WRITE  = 3'b011,
      AWSP_S_VERIFY = 3'b100,
      AWSP_S_NEXT   = 3'b101
   } awsp_state_t;
endpackage

// ===== design/awsp_sticky_bit.sv
// Purpose: one sticky flag, set by hardware and cleared by software
// Assumes: set and clear are single-cycle strobes in the clk domain
// Notes:   a set in the cycle of a clear wins
`timescale 1ns/1ps
`default_nettype none
module awsp_sticky_bit (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic set,
   input  wire logic clr,
   output logic      q
);
   // set has priority so an event is never lost
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         q <= 1'b0;
      end else if (set) begin
         q <= 1'b1;
      end else if (clr) begin
         q <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ===== design/awsp_word_counter.sv
// Purpose: counts data words of one sector and flags the last one
// Assumes: step is one cycle per word written
// Notes:   clear restarts the count at zero
`timescale 1ns/1ps
`default_nettype none
module awsp_word_counter #(
   parameter int WORDS = 256
) (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic clear,
   input  wire logic step,
   output logic      last
);
   localparam int CW = $clog2(WORDS);
   localparam logic [CW-1:0] LAST_IDX = CW'(WORDS - 1);
   logic [CW-1:0] count_reg; // words taken so far

   // refuse a sector of fewer than two words
   if (WORDS < 2) begin : g_chk
      $error("awsp_word_counter: WORDS must be at least 2");
   end

   // word count, wraps to zero after the last word
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         count_reg <= '0;
      end else if (clear) begin
         count_reg <= '0;
      end else if (step) begin
         count_reg <= (count_reg == LAST_IDX) ? '0 : count_reg + 1'b1;
      end
   end

   assign last = step && (count_reg == LAST_IDX);
endmodule
`default_nettype wire

// ===== design/awsp_core.sv
// Purpose: device side of the sector write commands on a task file
// Assumes: media back end answers each request with one done pulse
// Notes:   task file writes other than data are ignored while a command is running
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - opcodes 30h/31h write 1-256 sectors, 0=256
// - start at task file address, consecutive sectors
// - set busy, then drq without busy
// - no interrupt before the first sector
// - after a sector, busy up, drq down
// - next sector ready: drq, no busy, interrupt
// - last sector written: busy down, interrupt
// - error stops at failing sector, address kept
// - sector count holds sectors still remaining
// - opcode 3Ch also verifies each written sector
// - lba split over head, cylinders, sector number
// - f5h without security: no-op, count 00h
// - f5h with security: freeze lock
// - error ends command, later sectors not taken
module awsp_core
   import awsp_pkg::*;
#(
   parameter int WORDS_PER_SECTOR = AWSP_WORDS_DEF
) (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   output logic             intrq,
   output logic             irq,
   output logic             media_req,
   output logic             media_verify,
   output logic      [27:0] media_lba,
   output logic      [15:0] media_wdata,
   output logic             media_wvalid,
   input  wire logic        media_done,
   input  wire logic        media_err
);
   awsp_state_t state_reg;          // command sequencer state
   logic [7:0]  feature_reg;        // feature byte, kept for software
   logic [7:0]  sector_count_reg;   // sectors left, 0 means 256
   logic [7:0]  sector_number_reg;  // lba 7-0
   logic [7:0]  cylinder_low_reg;   // lba 15-8
   logic [7:0]  cylinder_high_reg;  // lba 23-16
   logic [7:0]  drive_head_reg;     // lba 27-24 in low nibble
   logic [7:0]  opcode_reg;         // last accepted opcode
   logic [7:0]  error_reg;          // error bits of the last command
   logic        err_flag_reg;       // status err bit
   logic        bsy_reg;            // status busy
   logic        drq_reg;            // status data request
   logic        verify_mode_reg;    // command verifies each sector
   logic        intrq_reg;          // host interrupt level
   logic        secure_reg;         // security feature set present
   logic        frozen_reg;         // freeze lock taken
   logic [AWSP_EV_N-1:0] irq_en_reg;  // event enables
   logic [AWSP_EV_N-1:0] irq_stat;    // sticky events
   logic [AWSP_EV_N-1:0] ev_set;      // event pulses this cycle
   logic [15:0] rdata_reg;          // read answer
   logic        irq_reg;            // system interrupt level
   logic        media_req_reg;      // media request pulse
   logic        media_verify_reg;   // request is a verify pass
   logic [15:0] media_wdata_reg;    // data word to media
   logic        media_wvalid_reg;   // data word strobe
   logic        word_last;          // last word of the sector taken
   logic [27:0] lba;                // current sector address
   logic [27:0] lba_next;           // following sector address

   // strobes decoded from the register port
   logic wr_cmd, wr_data, rd_status, wr_irqclr, tf_open;
   assign tf_open   = (state_reg == AWSP_S_IDLE);
   assign wr_cmd    = reg_wr && (reg_addr == AWSP_OFF_CMD) && tf_open;
   assign wr_data   = reg_wr && (reg_addr == AWSP_OFF_DATA) && drq_reg;
   assign rd_status = reg_rd && (reg_addr == AWSP_OFF_CMD);
   assign wr_irqclr = reg_wr && (reg_addr == AWSP_OFF_IRQCLR);

   // address assembly across the task file
   assign lba      = {drive_head_reg[3:0], cylinder_high_reg, cylinder_low_reg,
                      sector_number_reg};
   assign lba_next = lba + AWSP_LBA_STEP;

   // opcode classes
   logic op_write, op_wear;
   assign op_write = (reg_wdata[7:0] == AWSP_OP_WRITE_A) ||
                     (reg_wdata[7:0] == AWSP_OP_WRITE_B) ||
                     (reg_wdata[7:0] == AWSP_OP_WVERIFY);
   assign op_wear  = (reg_wdata[7:0] == AWSP_OP_WEAR);

   // media answer outcome
   logic media_fail, media_ok;
   assign media_fail = media_done && media_err;
   assign media_ok   = media_done && !media_err;
   logic last_sector;
   assign last_sector = (sector_count_reg == AWSP_SECCNT_ONE);

   // sector word counter
   awsp_word_counter #(
      .WORDS (WORDS_PER_SECTOR)
   ) u_words (
      .clk    (clk),
      .resetn (resetn),
      .clear  (wr_cmd),
      .step   (wr_data),
      .last   (word_last)
   );

   // command sequencer with busy and drq flags
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg       <= AWSP_S_IDLE;
         bsy_reg         <= 1'b0;
         drq_reg         <= 1'b0;
         verify_mode_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            AWSP_S_IDLE: begin
               // a write opcode raises busy first
               if (wr_cmd && op_write) begin
                  state_reg       <= AWSP_S_START;
                  bsy_reg         <= 1'b1;
                  verify_mode_reg <= (reg_wdata[7:0] == AWSP_OP_WVERIFY);
               end
            end
            AWSP_S_START: begin
               // open the first sector without an interrupt
               state_reg <= AWSP_S_DRQ;
               bsy_reg   <= 1'b0;
               drq_reg   <= 1'b1;
            end
            AWSP_S_DRQ: begin
               // buffer full: busy while the sector is written
               if (word_last) begin
                  state_reg <= AWSP_S_WRITE;
                  bsy_reg   <= 1'b1;
                  drq_reg   <= 1'b0;
               end
            end
            AWSP_S_WRITE: begin
               if (media_fail) begin
                  // stop at the failing sector
                  state_reg <= AWSP_S_IDLE;
                  bsy_reg   <= 1'b0;
               end else if (media_ok) begin
                  state_reg <= verify_mode_reg ? AWSP_S_VERIFY : AWSP_S_NEXT;
               end
            end
            AWSP_S_VERIFY: begin
               if (media_fail) begin
                  state_reg <= AWSP_S_IDLE;
                  bsy_reg   <= 1'b0;
               end else if (media_ok) begin
                  state_reg <= AWSP_S_NEXT;
               end
            end
            AWSP_S_NEXT: begin
               bsy_reg <= 1'b0;
               if (last_sector) begin
                  state_reg <= AWSP_S_IDLE;
               end else begin
                  state_reg <= AWSP_S_DRQ;
                  drq_reg   <= 1'b1;
               end
            end
            default: begin
               state_reg <= AWSP_S_IDLE;
               bsy_reg   <= 1'b0;
               drq_reg   <= 1'b0;
            end
         endcase
      end
   end

   // task file address and count; software loads only while idle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         feature_reg       <= '0;
         sector_count_reg  <= '0;
         sector_number_reg <= '0;
         cylinder_low_reg  <= '0;
         cylinder_high_reg <= '0;
         drive_head_reg    <= '0;
      end else if (reg_wr && tf_open) begin
         unique case (reg_addr)
            AWSP_OFF_FEATURE: feature_reg       <= reg_wdata[7:0];
            AWSP_OFF_SECCNT:  sector_count_reg  <= reg_wdata[7:0];
            AWSP_OFF_SECNUM:  sector_number_reg <= reg_wdata[7:0];
            AWSP_OFF_CYLLO:   cylinder_low_reg  <= reg_wdata[7:0];
            AWSP_OFF_CYLHI:   cylinder_high_reg <= reg_wdata[7:0];
            AWSP_OFF_DRVHD:   drive_head_reg    <= reg_wdata[7:0];
            // wear level without security reports no levelling needed
            AWSP_OFF_CMD: if (op_wear && !secure_reg) begin
               sector_count_reg <= AWSP_SECCNT_NONE;
            end
            default: ;
         endcase
      end else if (state_reg == AWSP_S_NEXT && !last_sector) begin
         // advance to the next sector; on error nothing moves
         sector_count_reg  <= sector_count_reg - AWSP_SECCNT_ONE;
         sector_number_reg <= lba_next[7:0];
         cylinder_low_reg  <= lba_next[15:8];
         cylinder_high_reg <= lba_next[23:16];
         drive_head_reg    <= {drive_head_reg[7:4], lba_next[27:24]};
      end else if (state_reg == AWSP_S_NEXT) begin
         sector_count_reg <= AWSP_SECCNT_NONE;
      end
   end

   // opcode, error byte and freeze lock
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         opcode_reg   <= '0;
         error_reg    <= '0;
         err_flag_reg <= 1'b0;
         frozen_reg   <= 1'b0;
      end else if (wr_cmd) begin
         opcode_reg   <= reg_wdata[7:0];
         error_reg    <= '0;
         err_flag_reg <= !(op_write || op_wear);
         error_reg[AWSP_ER_ABRT] <= !(op_write || op_wear);
         if (op_wear && secure_reg) begin
            frozen_reg <= 1'b1;
         end
      end else if (media_fail && (state_reg == AWSP_S_WRITE ||
                                  state_reg == AWSP_S_VERIFY)) begin
         err_flag_reg             <= 1'b1;
         error_reg[AWSP_ER_MEDIA] <= 1'b1;
      end
   end

   // event pulses
   always_comb begin
      ev_set = '0;
      ev_set[AWSP_EV_DRQ]  = (state_reg == AWSP_S_NEXT) && !last_sector;
      ev_set[AWSP_EV_DONE] = ((state_reg == AWSP_S_NEXT) && last_sector) ||
                             (wr_cmd && !op_write);
      ev_set[AWSP_EV_ERR]  = media_fail && (state_reg == AWSP_S_WRITE ||
                                            state_reg == AWSP_S_VERIFY);
   end

   // host interrupt level, cleared by a status read, set wins
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         intrq_reg <= 1'b0;
      end else if (|ev_set) begin
         intrq_reg <= 1'b1;
      end else if (rd_status) begin
         intrq_reg <= 1'b0;
      end
   end

   // sticky event flags for the system interrupt
   for (genvar i = 0; i < AWSP_EV_N; i++) begin : g_ev
      awsp_sticky_bit u_bit (
         .clk    (clk),
         .resetn (resetn),
         .set    (ev_set[i]),
         .clr    (wr_irqclr && reg_wdata[i]),
         .q      (irq_stat[i])
      );
   end

   // enables, security option and system interrupt level
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq_en_reg <= '0;
         secure_reg <= 1'b0;
         irq_reg    <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == AWSP_OFF_IRQEN) begin
            irq_en_reg <= reg_wdata[AWSP_EV_N-1:0];
         end
         if (reg_wr && reg_addr == AWSP_OFF_CONFIG && tf_open) begin
            secure_reg <= reg_wdata[AWSP_CF_SECURE];
         end
         irq_reg <= |(irq_stat & irq_en_reg);
      end
   end

   // media requests and data stream
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         media_req_reg    <= 1'b0;
         media_verify_reg <= 1'b0;
         media_wdata_reg  <= '0;
         media_wvalid_reg <= 1'b0;
      end else begin
         media_wvalid_reg <= wr_data;
         if (wr_data) begin
            media_wdata_reg <= reg_wdata;
         end
         // one request per write pass and per verify pass
         media_req_reg    <= (state_reg == AWSP_S_DRQ && word_last) ||
                             (state_reg == AWSP_S_WRITE && media_ok && verify_mode_reg);
         media_verify_reg <= (state_reg == AWSP_S_WRITE && media_ok) ? verify_mode_reg :
                             (state_reg == AWSP_S_DRQ) ? 1'b0 : media_verify_reg;
      end
   end

   // read answer, one cycle after the strobe
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata_reg <= '0;
      end else begin
         rdata_reg <= '0;
         if (reg_rd) begin
            unique case (reg_addr)
               AWSP_OFF_FEATURE: rdata_reg[7:0] <= error_reg;
               AWSP_OFF_SECCNT:  rdata_reg[7:0] <= sector_count_reg;
               AWSP_OFF_SECNUM:  rdata_reg[7:0] <= sector_number_reg;
               AWSP_OFF_CYLLO:   rdata_reg[7:0] <= cylinder_low_reg;
               AWSP_OFF_CYLHI:   rdata_reg[7:0] <= cylinder_high_reg;
               AWSP_OFF_DRVHD:   rdata_reg[7:0] <= drive_head_reg;
               AWSP_OFF_CMD: begin
                  rdata_reg[AWSP_ST_BSY]  <= bsy_reg;
                  rdata_reg[AWSP_ST_DRDY] <= !bsy_reg;
                  rdata_reg[AWSP_ST_DRQ]  <= drq_reg;
                  rdata_reg[AWSP_ST_ERR]  <= err_flag_reg;
               end
               AWSP_OFF_IRQSTAT: rdata_reg[AWSP_EV_N-1:0] <= irq_stat;
               AWSP_OFF_IRQEN:   rdata_reg[AWSP_EV_N-1:0] <= irq_en_reg;
               AWSP_OFF_CONFIG: begin
                  rdata_reg[AWSP_CF_SECURE] <= secure_reg;
                  rdata_reg[AWSP_CF_FROZEN] <= frozen_reg;
               end
               default: ;
            endcase
         end
      end
   end

   // outputs straight from flip-flops
   assign reg_rdata    = rdata_reg;
   assign intrq        = intrq_reg;
   assign irq          = irq_reg;
   assign media_req    = media_req_reg;
   assign media_verify = media_verify_reg;
   assign media_lba    = lba;
   assign media_wdata  = media_wdata_reg;
   assign media_wvalid = media_wvalid_reg;

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence s_cmd_taken;
      (state_reg == AWSP_S_IDLE) && wr_cmd && op_write;
   endsequence
   sequence s_busy_then_drq;
      (bsy_reg && !drq_reg) ##1 (!bsy_reg && drq_reg && !intrq_reg);
   endsequence

   a_start_handshake: assert property (
      s_cmd_taken and (!intrq_reg) |=> s_busy_then_drq)
      else $error("write command did not give busy then drq");
   a_first_no_irq: assert property (
      (state_reg == AWSP_S_START) |=> !$rose(intrq_reg))
      else $error("interrupt raised before first sector");
   a_sector_busy: assert property (
      (state_reg == AWSP_S_DRQ && word_last) |=> bsy_reg && !drq_reg ##1 bsy_reg)
      else $error("sector end did not raise busy and drop drq");
   a_next_sector: assert property (
      (state_reg == AWSP_S_NEXT && !last_sector) |=> !bsy_reg && drq_reg && intrq_reg)
      else $error("next sector not offered with interrupt");
   a_done_irq: assert property (
      (state_reg == AWSP_S_NEXT && last_sector) |=> !bsy_reg && !drq_reg && intrq_reg)
      else $error("completion without interrupt");
   a_error_stop: assert property (
      ev_set[AWSP_EV_ERR] |=> (state_reg == AWSP_S_IDLE) && $stable(media_lba)
                               && err_flag_reg)
      else $error("error did not stop at failing sector");
   a_residual: assert property (
      (state_reg == AWSP_S_NEXT && !last_sector) |=>
         sector_count_reg == $past(sector_count_reg) - AWSP_SECCNT_ONE)
      else $error("sector count not decremented");
   a_verify_pass: assert property (
      (state_reg == AWSP_S_WRITE && media_ok && verify_mode_reg) |=>
         (state_reg == AWSP_S_VERIFY) && media_req_reg && media_verify_reg)
      else $error("verify pass not issued");
   a_wear_nop: assert property (
      (wr_cmd && op_wear && !secure_reg) |=>
         sector_count_reg == AWSP_SECCNT_NONE && !bsy_reg && intrq_reg)
      else $error("wear level did not return zero count");
   a_irq_hold: assert property (
      (intrq_reg && !rd_status) |=> intrq_reg)
      else $error("interrupt dropped without status read");
endmodule
`default_nettype wire

// ===== test/awsp_media_model.sv
// Purpose: media back end answering each request after a varying delay
// Assumes: one request open at a time
// Notes:   media_err is noise outside media_done
`timescale 1ns/1ps
`default_nettype none
module awsp_media_model (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       media_req,
   input  wire logic       media_verify,
   input  wire logic       media_fail,
   output logic            media_done,
   output logic            media_err,
   output logic      [7:0] verify_count
);
   int wait_cnt; // cycles left before the answer
   // answer each request 2 to 10 cycles later, counting verify passes
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wait_cnt     <= 0;
         media_done   <= 1'b0;
         verify_count <= 8'h00;
      end else begin
         media_done <= (wait_cnt == 1);
         wait_cnt   <= (wait_cnt > 0) ? wait_cnt - 1 : 0;
         if (media_req) begin
            wait_cnt     <= 2 + int'($urandom % 9);
            verify_count <= verify_count + {7'h00, media_verify};
         end
      end
   end
   // failure flag only means something beside media_done
   assign media_err = media_done ? media_fail : ~media_fail;
endmodule
`default_nettype wire

// ===== test/testbench.sv
// Purpose: self-checking bench for the sector write command interpreter
// Assumes: sectors shortened to four words
// Notes:   addresses and data are random from a fixed seed
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
   checks_done++; \
   if ((g) !== (e)) begin \
      fails++; \
      $display("Error at %0t: got %h, want %h", $time, (g), (e)); \
   end \
end
module testbench;
   import awsp_pkg::*;
   localparam int W = 4; // words per sector
   logic        clk, resetn, reg_wr, reg_rd, intrq, irq, media_fail;
   logic        media_req, media_verify, media_wvalid, media_done, media_err;
   logic [3:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata, media_wdata, rd_val;
   logic [27:0] media_lba;
   logic [7:0]  verify_count;
   int          fails, checks_done, words_seen;
   awsp_core #(.WORDS_PER_SECTOR(W)) dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .intrq(intrq), .irq(irq), .media_req(media_req), .media_verify(media_verify),
      .media_lba(media_lba), .media_wdata(media_wdata), .media_wvalid(media_wvalid),
      .media_done(media_done), .media_err(media_err));
   awsp_media_model media (.clk(clk), .resetn(resetn), .media_req(media_req),
      .media_verify(media_verify), .media_fail(media_fail), .media_done(media_done),
      .media_err(media_err), .verify_count(verify_count));
   // data words handed to the media side
   always @(posedge clk) begin
      if (media_wvalid === 1'b1) words_seen++;
   end
   // one-cycle register write, then a quiet cycle
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask
   // one-cycle read, answer taken in the following cycle
   task automatic rd(input logic [3:0] a);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rd_val = reg_rdata;
      @(posedge clk);
   endtask
   // bounded wait for the host interrupt
   task automatic wait_int();
      #1;
      for (int k = 0; k < 400 && intrq !== 1'b1; k++) begin
         @(posedge clk);
         #1;
      end
      @(posedge clk);
   endtask
   // full write command; fail_at picks the sector whose write fails
   task automatic run_cmd(input logic [7:0] op, input logic [7:0] cnt, input int fail_at);
      int          n;
      logic [27:0] lba;
      logic [7:0]  nver;
      logic [15:0] d;
      int          nw;
      n = (cnt == 8'h00) ? 256 : int'(cnt);
      nw = words_seen;
      lba = 28'($urandom);
      nver = verify_count;
      media_fail <= 1'b0;
      wr(AWSP_OFF_SECCNT, {8'h00, cnt});
      wr(AWSP_OFF_SECNUM, {8'h00, lba[7:0]});
      wr(AWSP_OFF_CYLLO, {8'h00, lba[15:8]});
      wr(AWSP_OFF_CYLHI, {8'h00, lba[23:16]});
      wr(AWSP_OFF_DRVHD, {8'h00, 4'hE, lba[27:24]});
      wr(AWSP_OFF_CMD, {8'h00, op});
      for (int s = 0; s < n && s <= fail_at; s++) begin
         if (s == 0) begin
            // data waits until busy has cleared
            rd_val = 16'hFFFF;
            for (int k = 0; k < 20 && rd_val[AWSP_ST_BSY] !== 1'b0; k++) begin
               rd(AWSP_OFF_CMD);
            end
            `CHK(intrq, 1'b0)
         end else begin
            wait_int();
            `CHK(intrq, 1'b1)
            rd(AWSP_OFF_CMD);
         end
         `CHK(rd_val[7:0] & 8'h88, 8'h08)
         `CHK(media_lba, 28'(lba + s))
         media_fail <= (s == fail_at);
         for (int w = 0; w < W; w++) begin
            d = 16'($urandom);
            wr(AWSP_OFF_DATA, d);
            `CHK(media_wdata, d)
         end
         rd(AWSP_OFF_CMD);
         `CHK(rd_val[7:0] & 8'h88, 8'h80)
      end
      wait_int();
      rd(AWSP_OFF_CMD);
      `CHK(rd_val[7:0] & 8'h89, (fail_at < n) ? 8'h01 : 8'h00)
      `CHK(intrq, 1'b0)
      rd(AWSP_OFF_SECCNT);
      `CHK(rd_val, 16'((fail_at < n) ? n - fail_at : 0))
      rd(AWSP_OFF_SECNUM);
      if (fail_at < n) `CHK(rd_val[7:0], 8'(lba + fail_at))
      rd(AWSP_OFF_FEATURE);
      `CHK(rd_val, (fail_at < n) ? 16'h0040 : 16'h0000)
      `CHK(words_seen - nw, W * ((fail_at < n) ? fail_at + 1 : n))
      nver = 8'(verify_count - nver);
      `CHK(nver, (op == AWSP_OP_WVERIFY) ? 8'((fail_at < n) ? fail_at : n) : 8'h00)
      $display("command %h count %0d finished", op, cnt);
   endtask
   // wear level opcode with and without security support
   task automatic wear(input logic sec);
      wr(AWSP_OFF_CONFIG, {15'h0000, sec});
      wr(AWSP_OFF_SECCNT, 16'h0005);
      wr(AWSP_OFF_CMD, {8'h00, AWSP_OP_WEAR});
      wait_int();
      rd(AWSP_OFF_CMD);
      rd(sec ? AWSP_OFF_CONFIG : AWSP_OFF_SECCNT);
      `CHK(rd_val, sec ? 16'h0003 : 16'h0000)
      $display("wear level with security %0d finished", sec);
   endtask
   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // watchdog well beyond the expected run of under a thousand cycles
   initial begin
      repeat (30000) @(posedge clk);
      fails++;
      report_and_stop();
   end
   // main sequence
   initial begin
      void'($urandom(32'h2c9f_5e99));
      {resetn, reg_wr, reg_rd, media_fail, reg_addr, reg_wdata} = '0;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      rd(AWSP_OFF_SECCNT);
      `CHK(rd_val, 16'h0000)
      rd(4'hC);
      `CHK(rd_val, 16'h0000)
      $display("reset values checked");
      run_cmd(AWSP_OP_WRITE_A, 8'h01, 999);
      `CHK(irq, 1'b0)
      wr(AWSP_OFF_IRQEN, 16'h0002);
      rd(AWSP_OFF_IRQSTAT);
      `CHK({rd_val[AWSP_EV_DONE], irq}, 2'b11)
      wr(AWSP_OFF_IRQCLR, 16'h0007);
      rd(AWSP_OFF_IRQSTAT);
      `CHK({rd_val[2:0], irq}, 4'h0)
      $display("interrupt status checked");
      // an opcode outside the write family is aborted
      wr(AWSP_OFF_CMD, 16'h0077);
      wait_int();
      rd(AWSP_OFF_FEATURE);
      `CHK(rd_val, 16'h0004)
      rd(AWSP_OFF_CMD);
      `CHK(rd_val[7:0] & 8'h89, 8'h01)
      $display("unknown opcode checked");
      run_cmd(AWSP_OP_WRITE_B, 8'h03, 999);
      run_cmd(AWSP_OP_WVERIFY, 8'h02, 999);
      run_cmd(AWSP_OP_WRITE_A, 8'h04, 1);
      run_cmd(AWSP_OP_WVERIFY, 8'h03, 2);
      run_cmd(AWSP_OP_WRITE_B, 8'h00, 2);
      wear(1'b0);
      wear(1'b1);
      report_and_stop();
   end
endmodule
`default_nettype wire
